// >>> design/pse_pkg.sv
// Shared definitions for the program and system control execute block.
// Assumes a single core clock domain and one synchronous active-high reset.
package pse_pkg;

  // ****************************************************************
  // Opcode patterns and masks
  // ****************************************************************
  localparam logic [11:0] OP_SLEEP     = 12'h003;
  localparam logic [11:0] OP_RET       = 12'h00C;
  localparam logic [11:0] OP_RET_PAGE  = 12'h00D;
  localparam logic [11:0] OP_RET_INT   = 12'h00E;
  localparam logic [11:0] OP_RET_INTW  = 12'h00F;
  localparam logic [11:0] OP_PROG_RD   = 12'h041;
  localparam logic [11:0] OP_MOV_PC_W  = 12'h022;
  localparam logic [11:0] OP_ADD_PC_W  = 12'h1E2;
  localparam logic [11:0] OP_PAGE      = 12'h010;
  localparam logic [11:0] OP_BANK      = 12'h018;
  localparam logic [11:0] MASK_SEL3    = 12'hFF8;
  localparam logic [11:0] OP_CALL      = 12'h900;
  localparam logic [11:0] OP_RET_LIT   = 12'h800;
  localparam logic [11:0] MASK_LIT8    = 12'hF00;
  localparam logic [11:0] OP_JUMP      = 12'hA00;
  localparam logic [11:0] MASK_LIT9    = 12'hE00;
  localparam logic [11:0] OP_BIT_CLR   = 12'h400;
  localparam logic [11:0] OP_BIT_SET   = 12'h500;
  localparam logic [11:0] OP_SKIP_SET  = 12'h600;
  localparam logic [11:0] OP_SKIP_CLR  = 12'h700;

  // ****************************************************************
  // Cycle costs, counted as busy cycles after the taking cycle
  // ****************************************************************
  localparam logic [1:0] XTRA_FLOW  = 2'h2;
  localparam logic [1:0] XTRA_PROG  = 2'h3;
  localparam logic [1:0] XTRA_SKIP  = 2'h1;
  localparam logic [1:0] XTRA_NONE  = 2'h0;
  localparam logic [1:0] RD_CAPTURE = 2'h2;

  // ****************************************************************
  // Status and file-select layout, file addresses
  // ****************************************************************
  localparam int CARRY_BIT   = 0;
  localparam int ZERO_BIT    = 2;
  localparam int PWRDN_BIT   = 3;
  localparam int TO_BIT      = 4;
  localparam int PAGE_LO     = 5;
  localparam int BANK_LO     = 4;
  localparam logic [7:0] STATUS_KEEP = 8'h18;
  localparam logic [4:0] F_RTC      = 5'h01;
  localparam logic [4:0] F_PC       = 5'h02;
  localparam logic [4:0] F_STATUS   = 5'h03;
  localparam logic [4:0] F_FILE_SEL = 5'h04;

  // ****************************************************************
  // Register port map and reset values
  // ****************************************************************
  localparam logic [3:0] A_W      = 4'h0;
  localparam logic [3:0] A_STATUS = 4'h1;
  localparam logic [3:0] A_FILE_SEL = 4'h2;
  localparam logic [3:0] A_MODE   = 4'h3;
  localparam logic [3:0] A_PC_LO  = 4'h4;
  localparam logic [3:0] A_PC_HI  = 4'h5;
  localparam logic [3:0] A_RTC      = 4'h6;
  localparam logic [3:0] A_WATCHDOG = 4'h7;
  localparam logic [3:0] A_CTRL   = 4'h8;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [11:0] PC_RST    = 12'hFFF;
  localparam int STACK_DEPTH        = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [0:0] {
    PWR_RUN   = 1'b0,
    PWR_SLEEP = 1'b1
  } pse_pwr_t;

  typedef struct packed {
    logic [7:0]  w;
    logic [7:0]  status;
    logic [7:0]  file_sel;
    logic [3:0]  mode;
    logic [11:0] pc;
  } pse_arch_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] word;
  } pse_instr_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } pse_bus_t;

endpackage

// >>> design/pse_ret_stack.sv
// Return address stack held in flip-flops, newest entry at index zero.
// Assumes push and pop are never asked for in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module pse_ret_stack
  import pse_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [11:0] push_addr,
  output logic      [11:0] top
);

  typedef struct packed {
    logic [STACK_DEPTH-1:0][11:0] ent;
  } pse_stk_t;

  pse_stk_t st_q;
  pse_stk_t st_d;

  // Shift on push so a full stack silently drops its oldest entry
  always_comb begin
    st_d = st_q;
    if (push) begin
      for (int i = STACK_DEPTH - 1; i > 0; i--) begin
        st_d.ent[i] = st_q.ent[i-1]; // RQ15
      end
      st_d.ent[0] = push_addr;
    end else if (pop) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        st_d.ent[i] = st_q.ent[i+1];
      end
      st_d.ent[STACK_DEPTH-1] = '0;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign top = st_q.ent[0];

endmodule
`default_nettype wire

// >>> design/pse_exec.sv
// Execute unit for program flow and system control instructions.
// Assumes instructions arrive with a valid strobe only while busy is low,
// and that program memory answers a read with data one cycle later.
//
// How it works
// RQ1: Call pushes next address, loads literal low, clears bit 8, page on top.
// RQ2: Jump loads nine literal bits and page bits, three cycles.
// RQ3: Plain return pops stack into counter, page bits untouched, three cycles.
// RQ4: Page-restoring return also copies stacked bits 11:9 into page bits.
// RQ5: Interrupt return restores shadows except timeout and power-down bits.
// RQ6: Timer-adjust interrupt return also adds working register to counter.
// RQ7: Literal return loads literal into working register and pops, no flags.
// RQ8: Bank select writes operand into file select bits 6:4, one cycle.
// RQ9: Program read fetches word at mode:W into mode:W, four cycles.
// RQ10: Page select writes operand into status bits 7:5, one cycle.
// RQ11: Sleep clears watchdog, sets timeout, clears power-down, stops oscillator.
// RQ12: Bit-test skip costs one cycle when false, two when skipping.
// RQ13: Writing or adding W into counter location jumps, three cycles.
// RQ14: Carry sits at status bit 0, zero at bit 2.
// RQ15: Fixed-depth stack drops its oldest entry when pushed while full.
`timescale 1ns/1ns
`default_nettype none
module pse_exec
  import pse_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire pse_instr_t  instr,
  input  wire logic        irq_take,
  input  wire logic        watchdog_tick,
  input  wire logic        presc_on_watchdog,
  input  wire logic [11:0] pmem_rdata,
  input  wire pse_bus_t    bus,
  output logic      [7:0]  rdata,
  output pse_arch_t        arch,
  output logic      [7:0]  rtc_count,
  output logic      [7:0]  watchdog_count,
  output logic             busy,
  output logic             pmem_rd,
  output logic      [11:0] pmem_addr,
  output logic             presc_clr,
  output logic             osc_stop
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    pse_arch_t   arch;
    pse_arch_t   shadow;
    logic [7:0]  rtc;
    logic [7:0]  watchdog;
    logic [1:0]  cnt;
    logic        busy;
    logic        rd_pend;
    logic        pmem_rd;
    logic [11:0] pmem_addr;
    logic        presc_clr;
    pse_pwr_t    pwr;
    logic [7:0]  rdata;
  } pse_state_t;

  pse_state_t s_q;
  pse_state_t s_d;

  logic        push;
  logic        pop;
  logic [11:0] stack_top;
  logic [11:0] pc_next;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Match an opcode against a pattern under a mask
  function automatic logic op_is(input logic [11:0] word,
                                 input logic [11:0] pat,
                                 input logic [11:0] mask);
    op_is = ((word & mask) == pat);
  endfunction

  // Read one file location as seen by bit operations
  function automatic logic [7:0] file_rd(input pse_state_t s, input logic [4:0] f);
    case (f)
      F_RTC:      file_rd = s.rtc;
      F_PC:       file_rd = s.arch.pc[7:0];
      F_STATUS:   file_rd = s.arch.status;
      F_FILE_SEL: file_rd = s.arch.file_sel;
      default:  file_rd = 8'h00;
    endcase
  endfunction

  // Counter target for jumps through W: bit 8 cleared, page on top
  function automatic logic [11:0] pc_from(input logic [7:0] status,
                                          input logic [7:0] low);
    pc_from = {status[PAGE_LO+2:PAGE_LO], 1'b0, low};
  endfunction

  // ****************************************************************
  // Return stack
  // ****************************************************************
  pse_ret_stack u_stack (
    .core_clk  (core_clk),
    .rst       (rst),
    .push      (push),
    .pop       (pop),
    .push_addr (pc_next),
    .top       (stack_top)
  );

  assign pc_next = s_q.arch.pc + 12'h001;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [11:0] w;
    logic [4:0]  f;
    logic [2:0]  b;
    logic [7:0]  v;
    logic        take;
    s_d       = s_q;
    push      = 1'b0;
    pop       = 1'b0;
    w         = instr.word;
    f         = instr.word[4:0];
    b         = instr.word[7:5];
    v         = 8'h00;
    take      = instr.valid && !s_q.busy && (s_q.pwr == PWR_RUN);
    s_d.pmem_rd   = 1'b0;
    s_d.presc_clr = 1'b0;
    s_d.rdata     = 8'h00;

    // Watchdog count advances on its tick
    // Sleep further down clears it, so a tick in that cycle is lost
    if (watchdog_tick) begin
      s_d.watchdog = s_q.watchdog + 8'h01;
    end

    // Software register writes, instructions below take priority
    // so an instruction in the same cycle always wins over the port
    if (bus.wr) begin
      case (bus.addr)
        A_W:        s_d.arch.w = bus.wdata;
        A_STATUS:   s_d.arch.status = bus.wdata;
        A_FILE_SEL: s_d.arch.file_sel = bus.wdata;
        A_MODE:     s_d.arch.mode = bus.wdata[3:0];
        A_RTC:      s_d.rtc = bus.wdata;
        // Only a one in bit 0 wakes; a zero leaves the power state alone
        A_CTRL:     if (bus.wdata[0]) s_d.pwr = PWR_RUN;
        // Counter and watchdog are read-only from this port
        default:    ;
      endcase
    end

    // Register reads answer in the following cycle
    // Unmapped addresses and unused upper bits read as zero
    if (bus.rd) begin
      case (bus.addr)
        A_W:        s_d.rdata = s_q.arch.w;
        A_STATUS:   s_d.rdata = s_q.arch.status;
        A_FILE_SEL: s_d.rdata = s_q.arch.file_sel;
        A_MODE:     s_d.rdata = {4'h0, s_q.arch.mode};
        A_PC_LO:    s_d.rdata = s_q.arch.pc[7:0];
        A_PC_HI:    s_d.rdata = {4'h0, s_q.arch.pc[11:8]};
        A_RTC:      s_d.rdata = s_q.rtc;
        A_WATCHDOG: s_d.rdata = s_q.watchdog;
        A_CTRL:     s_d.rdata = {6'h00, s_q.pwr == PWR_SLEEP, s_q.busy};
        default:    s_d.rdata = 8'h00;
      endcase
    end

    // Busy countdown and late capture of a program word
    // Memory answers one cycle after the strobe, so the word is taken
    // while the count still shows two cycles to go
    if (s_q.busy) begin
      s_d.cnt  = s_q.cnt - 2'h1;
      s_d.busy = (s_q.cnt != 2'h1);
      if (s_q.rd_pend && s_q.cnt == RD_CAPTURE) begin
        s_d.arch.mode = pmem_rdata[11:8]; // RQ9
        s_d.arch.w    = pmem_rdata[7:0];
        s_d.rd_pend   = 1'b0;
      end
    end

    // Interrupt entry saves the shadow copies
    // Held off while busy so a half-done flow change is never saved
    if (irq_take && !s_q.busy) begin
      s_d.shadow = s_q.arch;
    end

    // Instruction execution
    // Default is one cycle and the next sequential address
    if (take) begin
      s_d.arch.pc = pc_next;
      s_d.cnt     = XTRA_NONE;
      if (op_is(w, OP_CALL, MASK_LIT8)) begin
        // Call: only eight literal bits, so bit 8 is always cleared
        push        = 1'b1;
        s_d.arch.pc = pc_from(s_q.arch.status, w[7:0]); // RQ1
        s_d.cnt     = XTRA_FLOW;
      end else if (op_is(w, OP_JUMP, MASK_LIT9)) begin
        // Jump: nine literal bits, page bits above them
        s_d.arch.pc = {s_q.arch.status[PAGE_LO+2:PAGE_LO], w[8:0]}; // RQ2
        s_d.cnt     = XTRA_FLOW;
      end else if (w == OP_RET) begin
        // Plain return leaves the page bits stale; callers beware
        pop         = 1'b1;
        s_d.arch.pc = stack_top; // RQ3
        s_d.cnt     = XTRA_FLOW;
      end else if (w == OP_RET_PAGE) begin
        // Page-restoring return realigns page bits with the counter
        pop         = 1'b1;
        s_d.arch.pc = stack_top; // RQ4
        s_d.arch.status[PAGE_LO+2:PAGE_LO] = stack_top[11:9];
        s_d.cnt     = XTRA_FLOW;
      end else if (w == OP_RET_INT || w == OP_RET_INTW) begin
        // Interrupt return: shadows back, live timeout and power-down kept
        s_d.arch = s_q.shadow; // RQ5
        s_d.arch.status = (s_q.shadow.status & ~STATUS_KEEP)
                        | (s_q.arch.status & STATUS_KEEP);
        if (w == OP_RET_INTW) begin
          // Adds the working register as it was before the restore
          s_d.rtc = s_q.rtc + s_q.arch.w; // RQ6
        end
        s_d.cnt = XTRA_FLOW;
      end else if (op_is(w, OP_RET_LIT, MASK_LIT8)) begin
        // Literal return: no flag is touched
        pop         = 1'b1;
        s_d.arch.w  = w[7:0]; // RQ7
        s_d.arch.pc = stack_top;
        s_d.cnt     = XTRA_FLOW;
      end else if (op_is(w, OP_BANK, MASK_SEL3)) begin
        // Bank select: single cycle, other file select bits kept
        s_d.arch.file_sel[BANK_LO+2:BANK_LO] = w[2:0]; // RQ8
      end else if (op_is(w, OP_PAGE, MASK_SEL3)) begin
        // Page select: single cycle, flags below kept
        s_d.arch.status[PAGE_LO+2:PAGE_LO] = w[2:0]; // RQ10
      end else if (w == OP_PROG_RD) begin
        // Program read: address frozen now, result lands two cycles on
        s_d.pmem_rd   = 1'b1; // RQ9
        s_d.pmem_addr = {s_q.arch.mode, s_q.arch.w};
        s_d.rd_pend   = 1'b1;
        s_d.cnt       = XTRA_PROG;
      end else if (w == OP_SLEEP) begin
        // Sleep: only a wake write or reset brings the unit back
        s_d.watchdog = 8'h00; // RQ11
        s_d.arch.status[TO_BIT] = 1'b1;
        s_d.arch.status[PWRDN_BIT] = 1'b0;
        s_d.presc_clr = presc_on_watchdog;
        s_d.pwr = PWR_SLEEP;
      end else if (w == OP_MOV_PC_W) begin
        // Indirect jump through the working register
        s_d.arch.pc = pc_from(s_q.arch.status, s_q.arch.w); // RQ13
        s_d.cnt     = XTRA_FLOW;
      end else if (w == OP_ADD_PC_W) begin
        // Relative jump; the low byte wraps inside its page
        s_d.arch.pc = pc_from(s_q.arch.status, pc_next[7:0] + s_q.arch.w); // RQ13
        s_d.cnt     = XTRA_FLOW;
      end else if (op_is(w, OP_SKIP_SET, MASK_LIT8) || op_is(w, OP_SKIP_CLR, MASK_LIT8)) begin
        v = file_rd(s_q, f);
        // Tested bit matches the opcode (set for 6xx, clear for 7xx): skip the next word and pay one extra cycle
        if (v[b] == op_is(w, OP_SKIP_SET, MASK_LIT8)) begin
          s_d.arch.pc = s_q.arch.pc + 12'h002; // RQ12
          s_d.cnt     = XTRA_SKIP;
        end
      end else if (op_is(w, OP_BIT_CLR, MASK_LIT8) || op_is(w, OP_BIT_SET, MASK_LIT8)) begin
        // Status bit ops reach carry at bit 0 and zero at bit 2
        // Counter low byte is not writable this way, it would break flow
        v    = file_rd(s_q, f);
        v[b] = op_is(w, OP_BIT_SET, MASK_LIT8); // RQ14
        case (f)
          F_RTC:      s_d.rtc = v;
          F_STATUS:   s_d.arch.status = v; // RQ14
          F_FILE_SEL: s_d.arch.file_sel = v;
          default:    ;
        endcase
      end

      // Busy follows whatever extra cycles the branch above chose
      s_d.busy = (s_d.cnt != XTRA_NONE);
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q        <= '0;
      s_q.arch.status <= STATUS_RST;
      s_q.arch.pc     <= PC_RST;
      s_q.pwr    <= PWR_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  // No logic between flops and pins, so the outputs never glitch

  // Register port answer, zero outside its one cycle
  assign rdata          = s_q.rdata;

  // Architectural state as seen by the rest of the core
  assign arch           = s_q.arch;

  // Counters
  assign rtc_count      = s_q.rtc;
  assign watchdog_count = s_q.watchdog;

  // Flow control towards the fetch side
  assign busy           = s_q.busy;

  // Program memory port; address held until the next read
  assign pmem_rd        = s_q.pmem_rd;
  assign pmem_addr      = s_q.pmem_addr;

  // Power control; the prescaler pulse lasts one cycle only
  assign presc_clr      = s_q.presc_clr;
  assign osc_stop       = (s_q.pwr == PWR_SLEEP);

endmodule
`default_nettype wire

// >>> tb/pse_exec_asserts.sv
// Timing checker for the program and system control execute block.
// Sees only the block's ports; one clock, synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module pse_exec_chk
  import pse_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire pse_instr_t  instr,
  input wire logic        presc_on_watchdog,
  input wire pse_arch_t   arch,
  input wire logic [7:0]  watchdog_count,
  input wire logic        busy,
  input wire logic        pmem_rd,
  input wire logic [11:0] pmem_addr,
  input wire logic        presc_clr,
  input wire logic        osc_stop
);
  // ****************
  // Accepted instruction
  // ****************
  logic        take;
  logic [11:0] op;
  // Valid is dropped while busy or stopped
  assign take = instr.valid && !busy && !osc_stop;
  assign op   = instr.word;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ****************
  // Properties
  // ****************
  chk_call_target: assert property (take && (op & MASK_LIT8) == OP_CALL
    |=> busy && arch.pc == {$past(arch.status[7:5]), 1'b0, $past(op[7:0])} ##1 busy ##1 !busy)
    else $error("call target or length wrong");
  chk_jump_target: assert property (take && (op & MASK_LIT9) == OP_JUMP
    |=> busy && arch.pc == {$past(arch.status[7:5]), $past(op[8:0])} ##1 busy ##1 !busy)
    else $error("jump target or length wrong");
  chk_ret_page: assert property (take && op == OP_RET_PAGE
    |=> arch.status[7:5] == arch.pc[11:9])
    else $error("page bits not restored");
  chk_ret_literal: assert property (take && (op & MASK_LIT8) == OP_RET_LIT
    |=> busy && arch.w == $past(op[7:0]) ##1 busy ##1 !busy)
    else $error("literal return wrong");
  chk_bank_sel: assert property (take && (op & MASK_SEL3) == OP_BANK
    |=> !busy && arch.file_sel[6:4] == $past(op[2:0]))
    else $error("bank select wrong");
  chk_page_sel: assert property (take && (op & MASK_SEL3) == OP_PAGE
    |=> !busy && arch.status[7:5] == $past(op[2:0]))
    else $error("page select wrong");
  chk_prog_read: assert property (take && op == OP_PROG_RD
    |=> pmem_rd && busy && pmem_addr == {$past(arch.mode), $past(arch.w)}
        ##1 busy[*2] ##1 !busy)
    else $error("program read wrong");
  chk_sleep_entry: assert property (take && op == OP_SLEEP
    |=> osc_stop && watchdog_count == 8'h00 && arch.status[TO_BIT] && !arch.status[PWRDN_BIT])
    else $error("sleep entry wrong");
  chk_presc_clear: assert property (take && op == OP_SLEEP && presc_on_watchdog
    |-> ##[1:2] presc_clr)
    else $error("prescaler not cleared");
  chk_presc_keep: assert property (take && op == OP_SLEEP && !presc_on_watchdog
    |=> !presc_clr)
    else $error("prescaler cleared while not on watchdog");
  chk_pc_write: assert property (take && (op == OP_MOV_PC_W || op == OP_ADD_PC_W)
    |=> busy[*2] ##1 !busy)
    else $error("counter write length wrong");

  // Main scenarios reached
  cov_call: cover property (take && (op & MASK_LIT8) == OP_CALL);
  cov_read: cover property (take && op == OP_PROG_RD);
  cov_sleep: cover property (take && op == OP_SLEEP);
endmodule

bind pse_exec pse_exec_chk u_chk (
  .core_clk(core_clk), .rst(rst), .instr(instr), .presc_on_watchdog(presc_on_watchdog),
  .arch(arch), .watchdog_count(watchdog_count), .busy(busy), .pmem_rd(pmem_rd),
  .pmem_addr(pmem_addr), .presc_clr(presc_clr), .osc_stop(osc_stop));
`default_nettype wire

// >>> tb/pse_exec_test.sv
// Self-checking bench for the program and system control execute block.
// Drives all ports itself; program memory data is preset before a read.
`timescale 1ns/1ns
`default_nettype none
module pse_exec_test
  import pse_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        irq_take = 1'b0;
  logic        watchdog_tick = 1'b0;
  logic        presc_on_watchdog = 1'b1;
  logic [11:0] pmem_rdata = 12'h000;
  pse_instr_t  instr = '0;
  pse_bus_t    bus = '0;
  logic [7:0]  rdata, rtc_count, watchdog_count, rv;
  pse_arch_t   arch, sh;
  logic        busy, pmem_rd, presc_clr, osc_stop;
  logic [11:0] pmem_addr, p;
  int          failures = 0;
  int          total_checks = 0;

  pse_exec dut (.core_clk(core_clk), .rst(rst), .instr(instr), .irq_take(irq_take),
    .watchdog_tick(watchdog_tick), .presc_on_watchdog(presc_on_watchdog),
    .pmem_rdata(pmem_rdata), .bus(bus), .rdata(rdata), .arch(arch),
    .rtc_count(rtc_count), .watchdog_count(watchdog_count),
    .busy(busy), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr), .presc_clr(presc_clr),
    .osc_stop(osc_stop));

  // 40 ns core clock
  initial forever #20 core_clk = ~core_clk;

  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One instruction; counts cycles until busy drops, bounded
  task automatic ex(input logic [11:0] w, input int cyc);
    int n;
    n = 1;
    @(posedge core_clk) instr <= '{1'b1, w};
    @(posedge core_clk) instr.valid <= 1'b0;
    #1;
    while (busy === 1'b1 && n < 9) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(12'(n), 12'(cyc));
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk) bus <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk) bus <= '0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk) bus <= '0;
    #1 d = rdata;
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    chk(arch.pc, PC_RST);
    rd(A_STATUS, rv);
    chk(12'(rv), 12'(STATUS_RST));
    rd(4'hF, rv);
    chk(12'(rv), 12'h000);
  endtask
  // Calls, jumps and returns across pages, then stack overflow
  task automatic t_flow();
    ex(12'h013, 1);
    chk(12'(arch.status[7:5]), 12'h003);
    ex(12'hBA5, 3);
    chk(arch.pc, 12'h7A5);
    ex(12'h942, 3);
    chk(arch.pc, 12'h642);
    ex(12'h010, 1);
    ex(OP_RET, 3);
    chk({arch.status[7:5], arch.pc[8:0]}, 12'h1A6);
    ex(12'h015, 1);
    ex(12'h910, 3);
    chk(arch.pc, 12'hA10);
    ex(OP_RET_PAGE, 3);
    chk({arch.status[7:5], arch.pc[8:0]}, 12'h7A8);
    ex(12'h920, 3);
    ex(12'h85A, 3);
    chk({arch.w, arch.pc[11:8]}, 12'h5A7);
    for (int i = 0; i < 9; i++) ex(12'h900 | 12'(i), 3);
    for (int i = 8; i >= 0; i--) begin
      ex(OP_RET, 3);
      chk(arch.pc, (i == 0) ? 12'h000 : 12'h600 + 12'(i));
    end
  endtask
  task automatic t_sysctl();
    wr(A_FILE_SEL, 8'h8F);
    ex(12'h01E, 1);
    chk(12'(arch.file_sel), 12'h0EF);
    wr(A_MODE, 8'h0A);
    wr(A_W, 8'h3C);
    pmem_rdata <= 12'h5B7;
    ex(OP_PROG_RD, 4);
    chk(pmem_addr, 12'hA3C);
    chk({arch.mode, arch.w}, 12'h5B7);
  endtask
  // Flags by bit ops, skips both ways, writes into the counter
  task automatic t_skip_pc();
    ex(12'h503, 1);
    ex(12'h543, 1);
    chk(12'({arch.status[ZERO_BIT], arch.status[CARRY_BIT]}), 12'h003);
    p = arch.pc;
    ex(12'h603, 2);
    ex(12'h743, 1);
    chk(arch.pc, p + 12'h003);
    ex(12'h403, 1);
    ex(12'h703, 2);
    chk(arch.pc, p + 12'h006);
    wr(A_W, 8'h30);
    ex(OP_MOV_PC_W, 3);
    chk(12'(arch.pc[7:0]), 12'h030);
    ex(OP_ADD_PC_W, 3);
    chk(12'(arch.pc[7:0]), 12'h061);
  endtask
  // Shadow capture, timer-adjust return, sleep, wake, plain interrupt return
  task automatic t_irq_sleep();
    wr(A_W, 8'h11);
    #1 sh = arch;
    @(posedge core_clk) irq_take <= 1'b1;
    @(posedge core_clk) irq_take <= 1'b0;
    wr(A_W, 8'h22);
    wr(A_RTC, 8'h40);
    ex(12'h017, 1);
    ex(OP_RET_INTW, 3);
    chk({rtc_count, arch.status[7:4]}, {8'h62, sh.status[7:4]});
    chk({arch.w, arch.pc[11:8]}, {8'h11, sh.pc[11:8]});
    @(posedge core_clk) watchdog_tick <= 1'b1;
    repeat (3) @(posedge core_clk);
    watchdog_tick <= 1'b0;
    ex(OP_SLEEP, 1);
    chk({watchdog_count, osc_stop, arch.status[4:3], presc_clr}, 12'h00D);
    p = arch.pc;
    ex(12'h942, 1);
    chk(arch.pc, p);
    wr(A_CTRL, 8'h01);
    ex(12'h018, 1);
    ex(OP_RET_INT, 3);
    chk({arch.mode, arch.file_sel}, {sh.mode, sh.file_sel});
    chk(12'(arch.status), 12'((sh.status & ~STATUS_KEEP) | 8'h10));
    chk(arch.pc, sh.pc);
    // Second sleep with the prescaler elsewhere: no clear pulse
    @(posedge core_clk) presc_on_watchdog <= 1'b0;
    ex(OP_SLEEP, 1);
    chk({watchdog_count, osc_stop, arch.status[4:3], presc_clr}, 12'h00C);
  endtask

  // ****************
  // Main sequence and watchdog
  // ****************
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_flow();
    t_sysctl();
    t_skip_pc();
    t_irq_sleep();
    tally_and_finish();
  end
  // Whole run needs some 200 cycles
  initial begin
    repeat (4000) @(posedge core_clk);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
